// ### core/l2cic_top.sv
// Summary of operation
// - Bit 25 set means byte-write decoding is done inside the device, clear means outside.
// - Fast-mode bit 24 at 0 allows back-to-back L2 burst read hits with no dead cycle.
// - Data RAM kind bits 23..22: 00 synchronous burst, 10 asynchronous, others reserved.
// - Write-timing code 01 gives normal write-enable timing and is the only asynchronous one.
// - Write-timing code 10 delays transfer acknowledge of a cache write by one cycle.
// - Write-timing code 11 asserts data RAM write enable in the same cycle as code 01, with transfer acknowledge.
// - Snoop wait bits 19..18 give 0 to 3 minimum address-phase wait clocks, reset 11.
// - Bit 17 sets active level of tag valid and dirty signals, 1 meaning active high.
// - Dirty pins used as second request and grant keep their own polarity.
// - Bit 16 sets active level of the hit input, 1 meaning active high, reset 0.
// - Bit 14 set makes the L2 ignore clean, flush and kill address-only transactions.
// - Bit 13 set holds tag address, tag valid and dirty out one clock after tag write ends.
// - Bit 12 set makes every bus transaction invalidate the tag entry it addresses.
// - The L2 is enabled only when its enable bit is set, the system has an L2 and the L2/MP config is not multiprocessor (11).
//
// The address-and-strobe port was decided locally.
`default_nettype none
module l2cic_top (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [1:0] l2_mp_config_in,
    input wire l2cic_pkg::l2cic_bus_t bus_in,
    input wire logic hit_raw_in,
    input wire logic tag_valid_raw_in,
    input wire logic dirty_in_or_second_request_in,
    input wire logic tag_write_in,
    input wire logic [15:0] tag_addr_in,
    input wire logic tag_valid_in,
    input wire logic dirty_in,
    input wire logic second_grant_in,
    output logic secondary_cache_enable_out,
    output logic internal_byte_write_decode_out,
    output logic async_ram_out,
    output logic cfg_reserved_code_out,
    output logic hit_out,
    output logic tag_valid_hit_out,
    output logic dirty_hit_out,
    output logic second_request_out,
    output logic transfer_acknowledge_out,
    output logic data_ram_write_enable_out,
    output logic burst_dead_cycle_out,
    output logic snoop_aack_out,
    output logic addr_only_respond_out,
    output logic invalidate_out,
    output logic tag_write_enable_out,
    output logic [15:0] tag_addr_out,
    output logic tag_valid_out,
    output logic dirty_out_or_second_grant_out
);
    logic [31:0] cfg_reg;
    logic [1:0] snoop_cnt_reg;
    logic snoop_busy_reg;
    logic ta_pend_reg;
    logic prev_burst_reg;
    logic hold_now;
    logic [15:0] hold_addr_reg;
    logic hold_tv_reg;
    logic hold_dirty_reg;

    logic l2_on;
    logic [1:0] wt;
    logic mod_hi;
    logic multi;
    assign wt = cfg_reg[l2cic_pkg::WR_TIMING_LSB +: 2];
    assign mod_hi = cfg_reg[l2cic_pkg::MOD_POL_BIT];
    assign multi = (l2_mp_config_in == l2cic_pkg::MP_MULTI);
    assign l2_on = cfg_reg[l2cic_pkg::SECONDARY_CACHE_ENABLE_BIT]
        && (l2_mp_config_in != l2cic_pkg::MP_NO_L2) && !multi;

    // The hold window is the one cycle in which the registered tag write
    // enable is still high while the core has already dropped its request.
    // Asynchronous tag RAM latches on the negating edge, so address, valid
    // and dirty must not move in that cycle.
    assign hold_now = tag_write_enable_out && !tag_write_in
        && cfg_reg[l2cic_pkg::HOLD_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Only implemented fields take writes; reserved bits stay zero.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_reg <= l2cic_pkg::RESET_VALUE;
        end else if (wr_in && addr_in == l2cic_pkg::PICR_TWO_OFFSET) begin
            cfg_reg <= wdata_in & l2cic_pkg::WRITABLE_MASK;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in && addr_in == l2cic_pkg::PICR_TWO_OFFSET) begin
            rdata_out <= cfg_reg;
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            secondary_cache_enable_out <= 1'b0;
            internal_byte_write_decode_out <= 1'b0;
            async_ram_out <= 1'b0;
            cfg_reserved_code_out <= 1'b0;
        end else begin
            secondary_cache_enable_out <= l2_on;
            internal_byte_write_decode_out <= cfg_reg[l2cic_pkg::BYTE_DECODE_BIT];
            async_ram_out <= (cfg_reg[l2cic_pkg::RAM_KIND_LSB +: 2]
                == l2cic_pkg::RAM_ASYNC);
            // Reserved RAM kinds and write codes, or a non-normal code on
            // asynchronous RAM, are flagged so firmware slips show up.
            cfg_reserved_code_out <= cfg_reg[l2cic_pkg::RAM_KIND_LSB]
                || (wt == 2'h0)
                || ((cfg_reg[l2cic_pkg::RAM_KIND_LSB +: 2] == l2cic_pkg::RAM_ASYNC)
                    && wt != l2cic_pkg::WT_NORMAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Polarity: XNOR with the polarity bit yields an active-high internal view.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hit_out <= 1'b0;
            tag_valid_hit_out <= 1'b0;
            dirty_hit_out <= 1'b0;
            second_request_out <= 1'b0;
        end else begin
            hit_out <= l2_on && (hit_raw_in ~^ cfg_reg[l2cic_pkg::HIT_POL_BIT]);
            tag_valid_hit_out <= tag_valid_raw_in ~^ mod_hi;
            dirty_hit_out <= !multi && (dirty_in_or_second_request_in ~^ mod_hi);
            second_request_out <= multi && dirty_in_or_second_request_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write timing: acknowledge and data RAM write enable for a cache write.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ta_pend_reg <= 1'b0;
            transfer_acknowledge_out <= 1'b0;
            data_ram_write_enable_out <= 1'b0;
        end else begin
            ta_pend_reg <= bus_in.write_req && l2_on && wt == l2cic_pkg::WT_DELAYED;
            transfer_acknowledge_out <= (wt == l2cic_pkg::WT_DELAYED) ? ta_pend_reg
                : (bus_in.write_req && l2_on);
            // Early mode raises the write enable from the request in the same
            // cycle as the acknowledge beat, just as normal mode does.
            data_ram_write_enable_out <= (wt == l2cic_pkg::WT_EARLY)
                ? (bus_in.write_req && l2_on)
                : (ta_pend_reg || (bus_in.write_req && l2_on
                    && wt != l2cic_pkg::WT_DELAYED));
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_burst_reg <= 1'b0;
            burst_dead_cycle_out <= 1'b0;
        end else begin
            prev_burst_reg <= bus_in.burst_read_hit && l2_on;
            burst_dead_cycle_out <= prev_burst_reg && bus_in.burst_read_hit
                && cfg_reg[l2cic_pkg::FAST_MODE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Snoop address phase: acknowledge after the programmed wait count.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            snoop_cnt_reg <= 2'h0;
            snoop_busy_reg <= 1'b0;
            snoop_aack_out <= 1'b0;
        end else begin
            snoop_aack_out <= 1'b0;
            if (!snoop_busy_reg && bus_in.snoop && l2_on) begin
                if (cfg_reg[l2cic_pkg::SNOOP_WS_LSB +: 2] == 2'h0) begin
                    snoop_aack_out <= 1'b1;
                end else begin
                    snoop_busy_reg <= 1'b1;
                    snoop_cnt_reg <= cfg_reg[l2cic_pkg::SNOOP_WS_LSB +: 2] - 2'h1;
                end
            end else if (snoop_busy_reg) begin
                if (snoop_cnt_reg == 2'h0) begin
                    snoop_busy_reg <= 1'b0;
                    snoop_aack_out <= 1'b1;
                end else begin
                    snoop_cnt_reg <= snoop_cnt_reg - 2'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            addr_only_respond_out <= 1'b0;
            invalidate_out <= 1'b0;
        end else begin
            addr_only_respond_out <= bus_in.addr_only && l2_on
                && !cfg_reg[l2cic_pkg::ADDR_ONLY_BIT];
            // Invalidate mode works with the cache still disabled so that
            // firmware can clear the tags before turning it on.
            invalidate_out <= cfg_reg[l2cic_pkg::INV_MODE_BIT]
                && (bus_in.write_req || bus_in.addr_only || bus_in.snoop
                    || bus_in.burst_read_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tag write: outputs follow the core, or hold one clock after the enable drops.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_addr_reg <= 16'h0000;
            hold_tv_reg <= 1'b0;
            hold_dirty_reg <= 1'b0;
            tag_write_enable_out <= 1'b0;
            tag_addr_out <= 16'h0000;
            tag_valid_out <= 1'b0;
            dirty_out_or_second_grant_out <= 1'b0;
        end else begin
            tag_write_enable_out <= tag_write_in;
            // The last written values are captured on every write cycle, so the
            // hold window always replays the final beat of the tag write.
            if (tag_write_in) begin
                hold_addr_reg <= tag_addr_in;
                hold_tv_reg <= tag_valid_in;
                hold_dirty_reg <= dirty_in;
            end
            if (hold_now) begin
                tag_addr_out <= hold_addr_reg;
                tag_valid_out <= hold_tv_reg ~^ mod_hi;
            end else begin
                tag_addr_out <= tag_addr_in;
                tag_valid_out <= tag_valid_in ~^ mod_hi;
            end
            if (multi) begin
                dirty_out_or_second_grant_out <= second_grant_in;
            end else if (hold_now) begin
                dirty_out_or_second_grant_out <= hold_dirty_reg ~^ mod_hi;
            end else begin
                dirty_out_or_second_grant_out <= dirty_in ~^ mod_hi;
            end
        end
    end
endmodule
`default_nettype wire

// ### core/l2cic_pkg.sv
`default_nettype none
package l2cic_pkg;
    localparam logic [7:0] PICR_TWO_OFFSET = 8'hac;
    localparam int BYTE_DECODE_BIT = 25;
    localparam int FAST_MODE_BIT = 24;
    localparam int RAM_KIND_LSB = 22;
    localparam int WR_TIMING_LSB = 20;
    localparam int SNOOP_WS_LSB = 18;
    localparam int MOD_POL_BIT = 17;
    localparam int HIT_POL_BIT = 16;
    localparam int ADDR_ONLY_BIT = 14;
    localparam int HOLD_BIT = 13;
    localparam int INV_MODE_BIT = 12;
    localparam int SECONDARY_CACHE_ENABLE_BIT = 30;
    localparam logic [31:0] WRITABLE_MASK = 32'h43ff_7000;
    localparam logic [31:0] RESET_VALUE = 32'h000c_0000;
    localparam logic [1:0] RAM_SYNC_BURST = 2'h0;
    localparam logic [1:0] RAM_ASYNC = 2'h2;
    localparam logic [1:0] WT_NORMAL = 2'h1;
    localparam logic [1:0] WT_DELAYED = 2'h2;
    localparam logic [1:0] WT_EARLY = 2'h3;
    localparam logic [1:0] MP_NO_L2 = 2'h0;
    localparam logic [1:0] MP_MULTI = 2'h3;

    typedef struct packed {
        logic write_req;
        logic addr_only;
        logic snoop;
        logic burst_read_hit;
    } l2cic_bus_t;
endpackage
`default_nettype wire

// ### tb/l2cic_monitor.sv
`default_nettype none
module l2cic_monitor (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [1:0] l2_mp_config_in,
    input wire l2cic_pkg::l2cic_bus_t bus_in,
    input wire logic secondary_cache_enable_out,
    input wire logic internal_byte_write_decode_out,
    input wire logic async_ram_out,
    input wire logic transfer_acknowledge_out,
    input wire logic data_ram_write_enable_out,
    input wire logic snoop_aack_out,
    input wire logic addr_only_respond_out,
    input wire logic invalidate_out
);
    logic [31:0] cfg_reg;
    logic wr_hit;
    logic en;
    assign wr_hit = wr_in && addr_in == l2cic_pkg::PICR_TWO_OFFSET;
    assign en = secondary_cache_enable_out;
    // A shadow of the register lets the timing checks know which modes are programmed.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_reg <= l2cic_pkg::RESET_VALUE;
        end else if (wr_hit) begin
            cfg_reg <= wdata_in & l2cic_pkg::WRITABLE_MASK;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    byte_decode_a: assert property (wr_hit |-> ##2 internal_byte_write_decode_out == $past(wdata_in[25], 2))
        else $error("byte decode output differs from written bit");
    ram_kind_a: assert property (wr_hit |-> ##2 async_ram_out == ($past(wdata_in[23:22], 2) == 2'h2))
        else $error("ram kind output differs from written field");
    reserved_read_a: assert property (rd_in && addr_in == 8'hac |=> rdata_out == cfg_reg)
        else $error("register read value wrong");
    ack_normal_a: assert property (bus_in.write_req && en && cfg_reg[21:20] == 2'h1
        |=> transfer_acknowledge_out && data_ram_write_enable_out) else $error("normal write late");
    ack_delay_a: assert property (bus_in.write_req && en && cfg_reg[21:20] == 2'h2
        |=> !transfer_acknowledge_out ##1 transfer_acknowledge_out) else $error("delayed ack wrong");
    early_we_a: assert property (bus_in.write_req && en && cfg_reg[21:20] == 2'h3
        |=> data_ram_write_enable_out) else $error("early write enable missing");
    snoop_wait_a: assert property (bus_in.snoop && en && cfg_reg[19:18] == 2'h3
        |=> !snoop_aack_out [*3] ##1 snoop_aack_out) else $error("snoop wait count wrong");
    no_l2_a: assert property (l2_mp_config_in == 2'h0 || l2_mp_config_in == 2'h3
        |=> !secondary_cache_enable_out) else $error("cache enabled without cache");
    addr_only_a: assert property (bus_in.addr_only && en
        |=> addr_only_respond_out == !cfg_reg[14]) else $error("address-only response wrong");
    invalidate_a: assert property (bus_in.write_req && cfg_reg[12] |=> invalidate_out)
        else $error("invalidate missing");
    cover property (bus_in.snoop ##[1:4] snoop_aack_out);
    cover property (transfer_acknowledge_out && cfg_reg[21:20] == 2'h2);
    cover property (invalidate_out);
endmodule
bind l2cic_top l2cic_monitor mon_u (.*);
`default_nettype wire

// ### tb/l2cic_ram_model.sv
`default_nettype none
module l2cic_ram_model (
    input wire logic mod_high_in,
    input wire logic hit_high_in,
    input wire logic hit_in,
    input wire logic valid_in,
    input wire logic dirty_in,
    output logic hit_raw_out,
    output logic tag_valid_raw_out,
    output logic dirty_raw_out
);
    // The tag RAM drives its lines at whatever active level the board was built for.
    assign hit_raw_out = hit_high_in ? hit_in : !hit_in;
    assign tag_valid_raw_out = mod_high_in ? valid_in : !valid_in;
    assign dirty_raw_out = mod_high_in ? dirty_in : !dirty_in;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 0, sys_rst_in = 1, wr_in = 0, rd_in = 0;
    logic [7:0] addr_in = '0;
    logic [31:0] wdata_in = '0, rdata;
    logic [1:0] mp = 2'h1;
    l2cic_pkg::l2cic_bus_t bus = '0;
    logic hit = 0, valid = 0, dty = 0, mod_high = 0, hit_high = 0, hit_raw, tv_raw, dirty_raw;
    logic en, bd, asy, hit_o, tv_o, sreq, ta, data_ram_write_enable, aack, ao, inv, rsv, dhit, dead;
    logic tw = 0, tvin = 0, twe_o, tv_pin, dout;
    logic [15:0] taddr = '0, taddr_o;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    l2cic_ram_model ram_u (.mod_high_in(mod_high), .hit_high_in(hit_high), .hit_in(hit),
        .valid_in(valid), .dirty_in(dty), .hit_raw_out(hit_raw), .tag_valid_raw_out(tv_raw),
        .dirty_raw_out(dirty_raw));
    l2cic_top dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .l2_mp_config_in(mp), .bus_in(bus), .hit_raw_in(hit_raw), .tag_valid_raw_in(tv_raw),
        .dirty_in_or_second_request_in(dirty_raw), .tag_write_in(tw), .tag_addr_in(taddr),
        .tag_valid_in(tvin), .dirty_in(tvin), .second_grant_in(1'b0),
        .secondary_cache_enable_out(en), .internal_byte_write_decode_out(bd),
        .async_ram_out(asy), .cfg_reserved_code_out(rsv), .hit_out(hit_o),
        .tag_valid_hit_out(tv_o), .dirty_hit_out(dhit), .second_request_out(sreq),
        .transfer_acknowledge_out(ta), .data_ram_write_enable_out(data_ram_write_enable),
        .burst_dead_cycle_out(dead), .snoop_aack_out(aack), .addr_only_respond_out(ao),
        .invalidate_out(inv), .tag_write_enable_out(twe_o), .tag_addr_out(taddr_o),
        .tag_valid_out(tv_pin), .dirty_out_or_second_grant_out(dout));
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic tick;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic cfg(input logic [31:0] d, input logic [7:0] a = 8'hac);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1;
        @(posedge mclk_in);
        wr_in <= 0;
        tick();
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] want);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1;
        @(posedge mclk_in);
        rd_in <= 0;
        #1 check(rdata, want);
    endtask
    task automatic pulse(input l2cic_pkg::l2cic_bus_t b);
        @(posedge mclk_in);
        bus <= b;
        @(posedge mclk_in);
        bus <= '0;
        #1;
    endtask
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        int n;
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 0;
        rd_reg(8'hac, l2cic_pkg::RESET_VALUE);
        rd_reg(8'h10, 32'h0);
        cfg(32'hffff_ffff, 8'h10);
        rd_reg(8'hac, l2cic_pkg::RESET_VALUE);
        cfg(32'hffff_ffff);
        rd_reg(8'hac, l2cic_pkg::WRITABLE_MASK);
        check({bd, asy}, 2'b10);
        check(rsv, 1'b1);
        cfg(32'h4090_0000);
        check({bd, asy}, 2'b01);
        check(rsv, 1'b0);
        for (k = 1; k < 4; k++) begin
            cfg(32'h4000_0000 + k * 32'h0010_0000);
            pulse(4'h8);
            check({ta, data_ram_write_enable}, {2{k != 2}});
            tick();
            check(ta, k == 2);
        end
        for (k = 0; k < 4; k++) begin
            cfg(32'h4000_0000 + k * 32'h0004_0000);
            pulse(4'h2);
            n = 1;
            while (aack !== 1'b1 && n < 10) begin
                tick();
                n++;
            end
            check(n, k + 1);
        end
        for (k = 0; k < 4; k++) begin
            cfg(32'h4000_0000 + k[1] * 32'h0003_0000);
            mod_high <= k[1];
            hit_high <= k[1];
            hit <= k[0];
            valid <= k[0];
            dty <= k[0];
            tick();
            tick();
            check({hit_o, tv_o, dhit}, {3{k[0]}});
        end
        for (k = 0; k < 2; k++) begin
            cfg(32'h4000_0000 + k * 32'h0000_4000);
            pulse(4'h4);
            check(ao, k == 0);
            cfg(k * 32'h0000_1000);
            pulse(4'h8);
            check(inv, k);
        end
        for (k = 0; k < 2; k++) begin
            cfg(32'h4000_0000 + k * 32'h0100_0000);
            @(posedge mclk_in);
            bus <= 4'h1;
            @(posedge mclk_in);
            @(posedge mclk_in);
            bus <= '0;
            #1 check(dead, k);
        end
        for (k = 0; k < 2; k++) begin
            cfg(32'h4002_0000 + k * 32'h0000_2000);
            @(posedge mclk_in);
            tw <= 1;
            taddr <= 16'h1234;
            tvin <= 1;
            @(posedge mclk_in);
            tw <= 0;
            taddr <= 16'h0000;
            tvin <= 0;
            @(posedge mclk_in);
            #1 check({twe_o, tv_pin, dout, taddr_o}, k ? 32'h0003_1234 : 32'h0);
        end
        for (k = 0; k < 4; k++) begin
            mp <= k[1:0];
            tick();
            tick();
            check(en, k == 1 || k == 2);
        end
        mod_high <= 1;
        dty <= 1;
        for (k = 0; k < 2; k++) begin
            cfg(32'h4000_0000 + k * 32'h0002_0000);
            tick();
            check({sreq, en}, 2'b10);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
